// ===== ddsrb_regbank.sv
// Configuration register bank: byte-wide buffer and active copies, update transfer
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Serial addresses 0x00-0x1B select 28 registers
// - Parallel mode exposes 112 byte-wide registers
// - Master reset restores all listed defaults
// - Writes held until update pulse or profile change
// - Setting DAC calibration enable starts calibration
// - Multi-bit fields are single binary words
module ddsrb_regbank #(
    parameter int N_REGS = ddsrb_pkg::NUM_SER_REGS,
    parameter int CAL_CYCLES = ddsrb_pkg::DAC_CAL_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // Serial-side word access
    input wire logic i_ser_wr,
    input wire logic i_ser_rd,
    input wire logic [4:0] i_ser_addr,
    input wire logic [31:0] i_ser_wdata,
    output logic [31:0] o_ser_rdata,
    output logic o_ser_rvalid,
    output logic o_ser_addr_err,
    // Parallel-side byte access
    input wire logic i_par_wr,
    input wire logic i_par_rd,
    input wire logic [6:0] i_par_addr,
    input wire logic [7:0] i_par_wdata,
    output logic [7:0] o_par_rdata,
    output logic o_par_rvalid,
    output logic o_par_addr_err,
    // Pins from outside the clock domain
    input wire logic i_io_update,
    input wire logic [2:0] i_profile_sel,
    input wire logic i_pll_lock,
    // Active register contents, update pulse and calibration status towards the core
    output logic [31:0] o_active_last_profile,
    output logic [2:0] o_sync_input_delay_adjust,
    output logic [2:0] o_sync_output_delay_adjust,
    output logic o_cal_with_sync,
    output logic o_update_pulse,
    output logic o_dac_cal_busy,
    output logic o_dac_cal_done
);
    localparam int NB = N_REGS * ddsrb_pkg::BYTES_PER_REG;
    localparam int LAST_BASE = int'(ddsrb_pkg::OFF_PROFILE7_WORD);
    localparam int USER_BASE = int'(ddsrb_pkg::OFF_USER_SYNC_DELAY_CTRL);
    localparam logic [1:0] PRIME_EDGES = 2'h3;

    logic [7:0] buf_ff [NB];
    logic [7:0] act_ff [NB];
    logic io_upd_s1_ff, io_upd_s2_ff, io_upd_s3_ff;
    logic [2:0] ps_s1_ff, ps_s2_ff, ps_s3_ff;
    logic lock_s1_ff, lock_s2_ff;
    logic [1:0] prime_ff;
    logic do_update;
    logic ser_hit, par_hit;
    logic cal_busy, cal_done;

    // Profile bits may land a cycle apart; that only costs one extra transfer
    // Two-stage synchronisers; third stage only for edge and change detect
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            io_upd_s1_ff <= 1'b0;
            io_upd_s2_ff <= 1'b0;
            io_upd_s3_ff <= 1'b0;
            ps_s1_ff <= 3'h0;
            ps_s2_ff <= 3'h0;
            ps_s3_ff <= 3'h0;
            lock_s1_ff <= 1'b0;
            lock_s2_ff <= 1'b0;
        end else begin
            io_upd_s1_ff <= i_io_update;
            io_upd_s2_ff <= io_upd_s1_ff;
            io_upd_s3_ff <= io_upd_s2_ff;
            ps_s1_ff <= i_profile_sel;
            ps_s2_ff <= ps_s1_ff;
            ps_s3_ff <= ps_s2_ff;
            lock_s1_ff <= i_pll_lock;
            lock_s2_ff <= lock_s1_ff;
        end
    end

    // Edge and change detect wait until the third stage holds a real pin sample,
    // so pins that stand high or off zero through reset cannot fake a transfer
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prime_ff <= 2'h0;
        end else if (prime_ff != PRIME_EDGES) begin
            prime_ff <= prime_ff + 2'h1;
        end
    end

    assign do_update = (prime_ff == PRIME_EDGES) &&
        ((io_upd_s2_ff && !io_upd_s3_ff) || (ps_s2_ff != ps_s3_ff));

    // Out-of-range accesses raise the error flag, write nothing and read as zero
    assign ser_hit = (i_ser_addr <= ddsrb_pkg::SER_ADDR_MAX);
    assign par_hit = (i_par_addr <= ddsrb_pkg::PAR_ADDR_MAX);

    // Listed reset value per byte; unlisted bytes start at zero
    function automatic logic [7:0] rst_val(input int idx);
        if (idx == int'(ddsrb_pkg::OFF_USER_FIXED_A)) begin
            rst_val = ddsrb_pkg::RST_USER_FIXED_A;
        end else if (idx == int'(ddsrb_pkg::OFF_USER_FIXED_B)) begin
            rst_val = ddsrb_pkg::RST_USER_FIXED_B;
        end else if (idx == int'(ddsrb_pkg::OFF_USER_SYNC_DELAY_CTRL)) begin
            rst_val = ddsrb_pkg::RST_USER_SYNC_DELAY_CTRL;
        end else begin
            rst_val = ddsrb_pkg::RST_DEFAULT_BYTE;
        end
    endfunction : rst_val

    // Per-byte buffer and active copy; serial word lane i%4 maps to byte i
    // The lock byte buffer never takes a write; reads rebuild it from the pin
    for (genvar i = 0; i < NB; i++) begin : g_byte
        localparam logic [7:0] RV = rst_val(i);
        logic ser_sel, par_sel;
        assign ser_sel = i_ser_wr && ser_hit && (i_ser_addr == 5'(i / 4));
        assign par_sel = i_par_wr && par_hit && (i_par_addr == 7'(i));
        always_ff @(posedge i_ref_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                buf_ff[i] <= RV;
            end else if (i == int'(ddsrb_pkg::OFF_USER_LOCK_STATUS)) begin
                buf_ff[i] <= RV;
            end else if (ser_sel) begin
                buf_ff[i] <= i_ser_wdata[(i % 4) * 8 +: 8];
            end else if (par_sel) begin
                buf_ff[i] <= i_par_wdata;
            end
        end
        always_ff @(posedge i_ref_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                act_ff[i] <= RV;
            end else if (do_update) begin
                act_ff[i] <= buf_ff[i];
            end
        end
    end

    // Reads return buffered contents; lock byte shows the live lock flag
    function automatic logic [7:0] rd_byte(input int idx);
        if (idx == int'(ddsrb_pkg::OFF_USER_LOCK_STATUS)) begin
            rd_byte = {7'h00, lock_s2_ff};
        end else begin
            rd_byte = buf_ff[idx];
        end
    endfunction : rd_byte

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ser_rdata <= 32'h0000_0000;
            o_ser_rvalid <= 1'b0;
            o_ser_addr_err <= 1'b0;
        end else begin
            o_ser_rvalid <= i_ser_rd && ser_hit;
            o_ser_addr_err <= (i_ser_rd || i_ser_wr) && !ser_hit;
            if (i_ser_rd && ser_hit) begin
                o_ser_rdata <= {rd_byte(int'(i_ser_addr) * 4 + 3), rd_byte(int'(i_ser_addr) * 4 + 2),
                                rd_byte(int'(i_ser_addr) * 4 + 1), rd_byte(int'(i_ser_addr) * 4)};
            end else if (i_ser_rd) begin
                o_ser_rdata <= 32'h0000_0000;
            end
        end
    end

    // Parallel reads see the same buffer bytes as serial word reads
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_par_rdata <= 8'h00;
            o_par_rvalid <= 1'b0;
            o_par_addr_err <= 1'b0;
        end else begin
            o_par_rvalid <= i_par_rd && par_hit;
            o_par_addr_err <= (i_par_rd || i_par_wr) && !par_hit;
            if (i_par_rd) begin
                o_par_rdata <= par_hit ? rd_byte(int'(i_par_addr)) : 8'h00;
            end
        end
    end

    // Active fields out, each as one binary word
    // Fields leave one edge after the transfer, so all of them change together
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_active_last_profile <= 32'h0000_0000;
            o_sync_input_delay_adjust <= 3'h0;
            o_sync_output_delay_adjust <= 3'h0;
            o_cal_with_sync <= 1'b0;
            o_update_pulse <= 1'b0;
            o_dac_cal_busy <= 1'b0;
            o_dac_cal_done <= 1'b0;
        end else begin
            o_active_last_profile <= {act_ff[LAST_BASE + 3], act_ff[LAST_BASE + 2],
                                      act_ff[LAST_BASE + 1], act_ff[LAST_BASE]};
            o_sync_input_delay_adjust <=
                act_ff[USER_BASE][ddsrb_pkg::SYNC_IN_ADJ_LSB +: ddsrb_pkg::SYNC_ADJ_W];
            o_sync_output_delay_adjust <=
                act_ff[USER_BASE][ddsrb_pkg::SYNC_OUT_ADJ_LSB +: ddsrb_pkg::SYNC_ADJ_W];
            o_cal_with_sync <= act_ff[USER_BASE][ddsrb_pkg::CAL_WITH_SYNC_BIT];
            o_update_pulse <= do_update;
            o_dac_cal_busy <= cal_busy;
            o_dac_cal_done <= cal_done;
        end
    end

    // Calibration runs from the transferred enable; host must toggle it
    ddsrb_dac_cal #(
        .CAL_CYCLES(CAL_CYCLES)
    ) u_dac_cal (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_cal_en(act_ff[ddsrb_pkg::OFF_DAC_CAL_BYTE][ddsrb_pkg::DAC_CAL_BIT]),
        .o_cal_busy(cal_busy),
        .o_cal_done(cal_done)
    );
endmodule : ddsrb_regbank
`default_nettype wire

// ===== ddsrb_pkg.sv
// Constants for the synthesizer configuration register bank
package ddsrb_pkg;
    localparam int NUM_SER_REGS = 28;
    localparam int NUM_PAR_REGS = 112;
    localparam int BYTES_PER_REG = 4;
    localparam logic [4:0] SER_ADDR_MAX = 5'h1b;
    localparam logic [6:0] PAR_ADDR_MAX = 7'h6f;
    localparam logic [6:0] OFF_PROFILE7_WORD = 7'h68;
    localparam logic [6:0] OFF_PROFILE7_AMP_LOW = 7'h6a;
    localparam logic [6:0] OFF_PROFILE7_AMP_HIGH = 7'h6b;
    localparam logic [6:0] OFF_USER_SYNC_DELAY_CTRL = 7'h6c;
    localparam logic [6:0] OFF_USER_FIXED_A = 7'h6d;
    localparam logic [6:0] OFF_USER_FIXED_B = 7'h6e;
    localparam logic [6:0] OFF_USER_LOCK_STATUS = 7'h6f;
    localparam logic [7:0] RST_USER_SYNC_DELAY_CTRL = 8'h00;
    localparam logic [7:0] RST_USER_FIXED_A = 8'h08;
    localparam logic [7:0] RST_USER_FIXED_B = 8'h00;
    localparam logic [7:0] RST_DEFAULT_BYTE = 8'h00;
    // Field positions in the user register sync and lock status bytes
    localparam int SYNC_IN_ADJ_LSB = 0;
    localparam int SYNC_OUT_ADJ_LSB = 3;
    localparam int SYNC_ADJ_W = 3;
    localparam int CAL_WITH_SYNC_BIT = 6;
    localparam int LOCK_BIT = 0;
    // DAC calibration enable bit: byte 0x03 (control register 1 top byte), bit 0
    localparam logic [6:0] OFF_DAC_CAL_BYTE = 7'h03;
    localparam int DAC_CAL_BIT = 0;
    // Calibration routine length in reference clocks
    localparam int DAC_CAL_CYCLES = 64;
endpackage : ddsrb_pkg

// ===== ddsrb_dac_cal.sv
// DAC capture timing calibration sequencer, started on rising enable
`timescale 1ns/1ps
`default_nettype none
module ddsrb_dac_cal #(
    parameter int CAL_CYCLES = ddsrb_pkg::DAC_CAL_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_cal_en,
    output logic o_cal_busy,
    output logic o_cal_done
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_DONE = 3'b100
    } ddsrb_cal_state_t;

    ddsrb_cal_state_t state_ff;
    ddsrb_cal_state_t nxt_state;
    logic [15:0] cnt_ff;
    logic en_d_ff;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            en_d_ff <= 1'b0;
        end else begin
            en_d_ff <= i_cal_en;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (i_cal_en && !en_d_ff) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (cnt_ff == 16'(CAL_CYCLES - 1)) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: begin
                // Held until software drops the enable, so a new run needs 0 then 1
                if (!i_cal_en) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 16'h0000;
            o_cal_busy <= 1'b0;
            o_cal_done <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= (nxt_state == ST_RUN && state_ff == ST_RUN) ? cnt_ff + 16'h0001 : 16'h0000;
            o_cal_busy <= (nxt_state == ST_RUN);
            o_cal_done <= (nxt_state == ST_DONE) || (o_cal_done && nxt_state == ST_IDLE);
        end
    end
endmodule : ddsrb_dac_cal
`default_nettype wire

// ===== ddsrb_regbank_chk.sv
// Port assertions for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module ddsrb_regbank_chk #(
    parameter int CAL_CYCLES = ddsrb_pkg::DAC_CAL_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_ser_wr,
    input wire logic i_ser_rd,
    input wire logic [4:0] i_ser_addr,
    input wire logic i_par_wr,
    input wire logic i_par_rd,
    input wire logic [6:0] i_par_addr,
    input wire logic i_io_update,
    input wire logic o_ser_rvalid,
    input wire logic o_ser_addr_err,
    input wire logic [7:0] o_par_rdata,
    input wire logic o_par_rvalid,
    input wire logic o_par_addr_err,
    input wire logic [31:0] o_active_last_profile,
    input wire logic o_update_pulse,
    input wire logic o_dac_cal_busy,
    input wire logic o_dac_cal_done
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    // Busy run length; a repetition would be too long to unroll
    int busy_cnt_ff;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) busy_cnt_ff <= 0;
        else busy_cnt_ff <= o_dac_cal_busy ? busy_cnt_ff + 1 : 0;
    end
    property p_ser_err;
        (i_ser_wr || i_ser_rd) |=> o_ser_addr_err == ($past(i_ser_addr) > 5'h1b);
    endproperty
    a_ser_err: assert property (p_ser_err) else $error("serial range flag wrong");
    property p_ser_rv; i_ser_rd && i_ser_addr <= 5'h1b |=> o_ser_rvalid; endproperty
    a_ser_rv: assert property (p_ser_rv) else $error("serial read not answered");
    property p_par_err;
        (i_par_wr || i_par_rd) |=> o_par_addr_err == ($past(i_par_addr) > 7'h6f);
    endproperty
    a_par_err: assert property (p_par_err) else $error("parallel range flag wrong");
    property p_par_rv; i_par_rd && i_par_addr <= 7'h6f |=> o_par_rvalid; endproperty
    a_par_rv: assert property (p_par_rv) else $error("parallel read not answered");
    property p_lock_ro; i_par_rd && i_par_addr == 7'h6f |=> o_par_rdata[7:1] == 7'h00; endproperty
    a_lock_ro: assert property (p_lock_ro) else $error("lock byte open bits set");
    property p_upd_lat; $rose(i_io_update) |-> ##[1:5] o_update_pulse; endproperty
    a_upd_lat: assert property (p_upd_lat) else $error("update pulse missing");
    property p_act_hold; !$stable(o_active_last_profile) |-> $past(o_update_pulse); endproperty
    a_act_hold: assert property (p_act_hold) else $error("active copy moved");
    property p_cal_len;
        $fell(o_dac_cal_busy) |-> o_dac_cal_done && busy_cnt_ff == CAL_CYCLES;
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
endmodule : ddsrb_regbank_chk
bind ddsrb_regbank ddsrb_regbank_chk #(.CAL_CYCLES(CAL_CYCLES)) ddsrb_regbank_chk_inst (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ser_wr(i_ser_wr), .i_ser_rd(i_ser_rd),
    .i_ser_addr(i_ser_addr), .i_par_wr(i_par_wr), .i_par_rd(i_par_rd), .i_par_addr(i_par_addr),
    .i_io_update(i_io_update), .o_ser_rvalid(o_ser_rvalid), .o_ser_addr_err(o_ser_addr_err),
    .o_par_rdata(o_par_rdata), .o_par_rvalid(o_par_rvalid), .o_par_addr_err(o_par_addr_err),
    .o_active_last_profile(o_active_last_profile), .o_update_pulse(o_update_pulse),
    .o_dac_cal_busy(o_dac_cal_busy), .o_dac_cal_done(o_dac_cal_done));
`default_nettype wire

// ===== ddsrb_host.sv
// Host controller model for the serial and parallel ports and pins
`timescale 1ns/1ps
`default_nettype none
module ddsrb_host (
    input wire logic i_ref_clk,
    input wire logic [31:0] i_ser_rdata,
    input wire logic i_ser_addr_err,
    input wire logic [7:0] i_par_rdata,
    input wire logic i_par_addr_err,
    output logic o_nrst,
    output logic o_ser_wr,
    output logic o_ser_rd,
    output logic [4:0] o_ser_addr,
    output logic [31:0] o_ser_wdata,
    output logic o_par_wr,
    output logic o_par_rd,
    output logic [6:0] o_par_addr,
    output logic [7:0] o_par_wdata,
    output logic o_io_update,
    output logic [2:0] o_profile_sel,
    output logic o_pll_lock
);
    initial {o_nrst, o_ser_wr, o_ser_rd, o_ser_addr, o_ser_wdata, o_par_wr, o_par_rd, o_par_addr,
        o_par_wdata, o_io_update, o_profile_sel, o_pll_lock} = '0;
    task automatic rst();
        @(negedge i_ref_clk);
        o_nrst = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        o_nrst = 1'b1;
    endtask : rst
    // One-cycle request, answer taken one cycle later
    task automatic op(input logic s, input logic w, input logic [6:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(negedge i_ref_clk);
        {o_ser_wr, o_ser_rd, o_par_wr, o_par_rd} = {s & w, s & !w, !s & w, !s & !w};
        o_ser_addr = a[4:0];
        o_par_addr = a;
        {o_ser_wdata, o_par_wdata} = {d, d[7:0]};
        @(negedge i_ref_clk);
        q = s ? i_ser_rdata : {24'h0, i_par_rdata};
        e = s ? i_ser_addr_err : i_par_addr_err;
        {o_ser_wr, o_ser_rd, o_par_wr, o_par_rd} = 4'h0;
        // Released data lines flip so stale values cannot match
        {o_ser_wdata, o_par_wdata} = ~{d, d[7:0]};
    endtask : op
    // Pins cross a synchroniser, so settle for several cycles
    task automatic pin(input logic u, input logic [2:0] p, input logic l);
        @(negedge i_ref_clk);
        {o_io_update, o_profile_sel, o_pll_lock} = {u, p, l};
        repeat (6) @(negedge i_ref_clk);
    endtask : pin
endmodule : ddsrb_host
`default_nettype wire

// ===== dds_control_register_bank_bench.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module dds_control_register_bank_bench;
    typedef struct packed {
        logic w;
        logic lk;
        logic [6:0] a;
        logic [7:0] d;
        logic [7:0] x;
        logic e;
    } ddsrb_row_t;
    localparam int CAL = 8;
    logic i_ref_clk = 1'b0;
    logic i_nrst, i_ser_wr, i_ser_rd, i_par_wr, i_par_rd, i_io_update, i_pll_lock, e;
    logic [4:0] i_ser_addr;
    logic [6:0] i_par_addr;
    logic [7:0] i_par_wdata, o_par_rdata;
    logic [2:0] i_profile_sel, o_sync_input_delay_adjust, o_sync_output_delay_adjust;
    logic [31:0] i_ser_wdata, o_ser_rdata, o_active_last_profile, q;
    logic o_ser_rvalid, o_ser_addr_err, o_par_rvalid, o_par_addr_err, o_cal_with_sync;
    logic o_update_pulse, o_dac_cal_busy, o_dac_cal_done;
    int n_fail = 0;
    int checked = 0;
    ddsrb_row_t rows [10] = '{
        '{1'b0, 1'b0, 7'h6c, 8'h00, 8'h00, 1'b0}, '{1'b0, 1'b0, 7'h6d, 8'h00, 8'h08, 1'b0},
        '{1'b0, 1'b0, 7'h6e, 8'h00, 8'h00, 1'b0}, '{1'b1, 1'b0, 7'h6a, 8'ha5, 8'ha5, 1'b0},
        '{1'b1, 1'b0, 7'h6b, 8'h3c, 8'h3c, 1'b0}, '{1'b1, 1'b0, 7'h6c, 8'h5e, 8'h5e, 1'b0},
        '{1'b1, 1'b1, 7'h6f, 8'hff, 8'h01, 1'b0}, '{1'b1, 1'b0, 7'h6f, 8'hff, 8'h00, 1'b0},
        '{1'b1, 1'b0, 7'h70, 8'h11, 8'h00, 1'b1}, '{1'b1, 1'b0, 7'h7f, 8'h22, 8'h00, 1'b1}};
    always #4 i_ref_clk = ~i_ref_clk;
    ddsrb_regbank #(.CAL_CYCLES(CAL)) ddsrb_regbank_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_ser_wr(i_ser_wr), .i_ser_rd(i_ser_rd), .i_ser_addr(i_ser_addr),
        .i_ser_wdata(i_ser_wdata), .o_ser_rdata(o_ser_rdata), .o_ser_rvalid(o_ser_rvalid),
        .o_ser_addr_err(o_ser_addr_err), .i_par_wr(i_par_wr), .i_par_rd(i_par_rd),
        .i_par_addr(i_par_addr), .i_par_wdata(i_par_wdata), .o_par_rdata(o_par_rdata),
        .o_par_rvalid(o_par_rvalid), .o_par_addr_err(o_par_addr_err),
        .i_io_update(i_io_update), .i_profile_sel(i_profile_sel), .i_pll_lock(i_pll_lock),
        .o_active_last_profile(o_active_last_profile),
        .o_sync_input_delay_adjust(o_sync_input_delay_adjust),
        .o_sync_output_delay_adjust(o_sync_output_delay_adjust),
        .o_cal_with_sync(o_cal_with_sync), .o_update_pulse(o_update_pulse),
        .o_dac_cal_busy(o_dac_cal_busy), .o_dac_cal_done(o_dac_cal_done));
    ddsrb_host host_inst (.i_ref_clk(i_ref_clk), .i_ser_rdata(o_ser_rdata),
        .i_ser_addr_err(o_ser_addr_err), .i_par_rdata(o_par_rdata), .i_par_addr_err(o_par_addr_err),
        .o_nrst(i_nrst), .o_ser_wr(i_ser_wr), .o_ser_rd(i_ser_rd), .o_ser_addr(i_ser_addr),
        .o_ser_wdata(i_ser_wdata), .o_par_wr(i_par_wr), .o_par_rd(i_par_rd),
        .o_par_addr(i_par_addr), .o_par_wdata(i_par_wdata), .o_io_update(i_io_update),
        .o_profile_sel(i_profile_sel), .o_pll_lock(i_pll_lock));
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
        checked++;
        if (s !== x) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic wrap_up();
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    initial begin
        host_inst.rst();
        foreach (rows[i]) begin
            host_inst.pin(1'b0, 3'h0, rows[i].lk);
            if (rows[i].w) host_inst.op(1'b0, 1'b1, rows[i].a, {24'h0, rows[i].d}, q, e);
            host_inst.op(1'b0, 1'b0, rows[i].a, 32'h0, q, e);
            chk("par_rdata", {24'h0, rows[i].x}, q);
            chk("par_addr_err", {31'h0, rows[i].e}, {31'h0, e});
        end
        host_inst.op(1'b1, 1'b0, 7'h1b, 32'h0, q, e);
        chk("ser_rdata", 32'h0000_085e, q);
        host_inst.op(1'b1, 1'b1, 7'h1a, 32'h0f12_3456, q, e);
        chk("active_hold", 32'h0, o_active_last_profile);
        host_inst.pin(1'b1, 3'h0, 1'b0);
        host_inst.pin(1'b0, 3'h0, 1'b0);
        chk("active_upd", 32'h0f12_3456, o_active_last_profile);
        host_inst.op(1'b1, 1'b0, 7'h1c, 32'h0, q, e);
        chk("ser_addr_err", 32'h1, {31'h0, e});
        host_inst.op(1'b0, 1'b1, 7'h6c, 32'h29, q, e);
        host_inst.pin(1'b0, 3'h5, 1'b0);
        chk("sync_fields", 32'h29, {25'h0, o_cal_with_sync, o_sync_output_delay_adjust,
            o_sync_input_delay_adjust});
        host_inst.op(1'b0, 1'b1, 7'h03, 32'h1, q, e);
        host_inst.pin(1'b1, 3'h5, 1'b0);
        host_inst.pin(1'b0, 3'h5, 1'b0);
        for (int k = 0; k < 40 && o_dac_cal_done !== 1'b1; k++) @(negedge i_ref_clk);
        chk("cal_done", 32'h1, {31'h0, o_dac_cal_done});
        host_inst.op(1'b0, 1'b1, 7'h03, 32'h0, q, e);
        host_inst.pin(1'b1, 3'h5, 1'b0);
        host_inst.rst();
        // Pins still stand high and off zero, so this write must not transfer
        host_inst.op(1'b0, 1'b1, 7'h68, 32'h77, q, e);
        host_inst.op(1'b0, 1'b0, 7'h6c, 32'h0, q, e);
        chk("reset_byte", 32'h0, q);
        chk("reset_active", 32'h0, o_active_last_profile);
        chk("reset_cal_done", 32'h0, {31'h0, o_dac_cal_done});
        host_inst.op(1'b0, 1'b0, 7'h6a, 32'h0, q, e);
        chk("reset_scale_low", 32'h0, q);
        wrap_up();
    end
    // Whole sequence runs under 2000 cycles
    initial begin
        #100000;
        n_fail++;
        wrap_up();
    end
endmodule : dds_control_register_bank_bench
`default_nettype wire
